// ===== hw/dgt_pkg.sv
package dgt_pkg;

  // ****************************************************
  // bus geometry
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // register indices, byte address is four times these
  // ****************************************************
  localparam logic [5:0] IDX_RX_FINE_GAIN = 6'h29;
  localparam logic [5:0] IDX_CHANNEL_FORMAT = 6'h2a;
  localparam logic [5:0] IDX_LEVEL_THRESHOLD = 6'h2b;
  localparam logic [5:0] IDX_LEVEL_IRQ_CTRL = 6'h2c;
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h2d;
  localparam logic [5:0] IDX_EVENT_MASK = 6'h2e;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int POS_FINE_DIR = 4;
  localparam int POS_FMT_LO = 2;
  localparam int POS_B2_EN = 1;
  localparam int POS_B1_EN = 0;
  localparam int POS_FLAG = 3;
  localparam int POS_SEL = 2;
  localparam int POS_MASK = 1;
  localparam int POS_POL = 0;
  localparam int POS_EVT_THRESH = 0;

  // ****************************************************
  // values after reset
  // ****************************************************
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_SAMPLE = 16'h0000;

  // ****************************************************
  // channel coding
  // ****************************************************
  typedef enum logic [1:0] {
    DGT_FMT_ALAW = 2'b00,
    DGT_FMT_MULAW = 2'b01,
    DGT_FMT_LIN8 = 2'b10,
    DGT_FMT_LIN16 = 2'b11
  } dgt_format_t;

  typedef enum logic [2:0] {
    DGT_SEL_NONE,
    DGT_SEL_GAIN,
    DGT_SEL_FORMAT,
    DGT_SEL_THRESH,
    DGT_SEL_IRQCTL,
    DGT_SEL_STATUS,
    DGT_SEL_MASK
  } dgt_sel_t;

  typedef struct packed {
    logic dir;
    logic [3:0] steps;
  } dgt_fine_gain_t;

  typedef struct packed {
    dgt_format_t fmt;
    logic b2_en;
    logic b1_en;
  } dgt_chan_ctl_t;

  typedef struct packed {
    logic flag;
    logic sel;
    logic mask;
    logic pol;
  } dgt_irq_ctl_t;

endpackage

// ===== hw/dgt_regs.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - reserved upper bits always read zero
// RULE2 - direction bit four: gain or attenuation
// RULE3 - tenth dB steps, zero steps no change
// RULE4 - format: A-law, mu-law, 8-bit linear
// RULE5 - code 11: 16-bit over both channels
// RULE6 - second channel enable gates its transfers
// RULE7 - 16-bit, second off: upper byte first
// RULE8 - first channel enable gates its transfers
// RULE9 - 16-bit, first off: lower byte second
// RULE10 - threshold register sets comparison level
// RULE11 - select bit picks current or voltage
// RULE12 - polarity: below or above absolute value
// RULE13 - flag sticks; software writes zero clears
// RULE14 - interrupt needs flag, mask, global enable; the code also raises it from event_status & event_mask while the flag is clear
// RULE15 - masked event still sets the flag
// RULE16 - writing one leaves flag unchanged
// RULE17 - compare on every measurement update
module dgt_regs (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [dgt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dgt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dgt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dgt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurements
  input wire logic [7:0] line_current_value,
  input wire logic [7:0] line_voltage_value,
  input wire logic measure_update,
  input wire logic global_irq_enable,
  output logic irq_output_pin,
  // receive fine gain
  output logic rx_fine_dir,
  output logic [3:0] rx_fine_steps,
  output logic signed [5:0] rx_fine_gain_tenths,
  // channel data path
  output logic [1:0] channel_data_format,
  input wire logic channel_assign,
  input wire logic [15:0] tx_sample,
  input wire logic [7:0] tx_coded,
  input wire logic tx_valid,
  output logic [7:0] b1_tx_byte,
  output logic b1_tx_valid,
  output logic [7:0] b2_tx_byte,
  output logic b2_tx_valid,
  input wire logic [7:0] b1_rx_byte,
  input wire logic [7:0] b2_rx_byte,
  input wire logic rx_valid,
  output logic [15:0] rx_sample,
  output logic [7:0] rx_coded,
  output logic rx_sample_valid
);
  import dgt_pkg::*;

  // ****************************************************
  // helpers
  // ****************************************************
  // byte address to register select; misaligned or unknown -> none
  function automatic dgt_sel_t dgt_decode(input logic [ADDR_W-1:0] a);
    dgt_sel_t s;
    s = DGT_SEL_NONE;
    if (a[1:0] == 2'b00) begin
      case (a[7:2])
        IDX_RX_FINE_GAIN: s = DGT_SEL_GAIN;
        IDX_CHANNEL_FORMAT: s = DGT_SEL_FORMAT;
        IDX_LEVEL_THRESHOLD: s = DGT_SEL_THRESH;
        IDX_LEVEL_IRQ_CTRL: s = DGT_SEL_IRQCTL;
        IDX_EVENT_STATUS: s = DGT_SEL_STATUS;
        IDX_EVENT_MASK: s = DGT_SEL_MASK;
        default: s = DGT_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // magnitude of a two's complement byte, nine bits so -128 fits
  function automatic logic [8:0] dgt_abs(input logic [7:0] v);
    logic [8:0] r;
    r = {v[7], v};
    if (v[7]) begin
      r = 9'(-$signed({v[7], v}));
    end
    return r;
  endfunction

  // ****************************************************
  // register state
  // ****************************************************
  dgt_fine_gain_t fine_gain;
  dgt_chan_ctl_t chan_ctl;
  logic [7:0] line_level_threshold;
  dgt_irq_ctl_t irq_ctl;
  logic level_flag;
  logic [2:0] ctl_low;
  logic [0:0] event_status;
  logic [0:0] event_mask;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic gie_meta;
  logic gie_sync;

  logic do_write;
  logic wr_lane0;
  dgt_sel_t wr_sel;
  dgt_sel_t rd_sel;
  logic rd_take;
  logic cross_now;
  logic [8:0] level_abs;
  logic [7:0] level_raw;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel = dgt_decode(aw_addr);
  assign wr_lane0 = do_write && w_strb[0];
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_sel = dgt_decode(s_axi_araddr);
  // flag and plain control bits live in separate processes
  assign irq_ctl = dgt_irq_ctl_t'({level_flag, ctl_low});

  // ****************************************************
  // axi write channel
  // ****************************************************
  // address and data are taken independently, committed together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == DGT_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************
  // axi read channel
  // ****************************************************
  // one read in flight; data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        // upper bits of every register zero filled [RULE1]
        case (rd_sel)
          DGT_SEL_GAIN: s_axi_rdata <= {27'h0, fine_gain};
          DGT_SEL_FORMAT: s_axi_rdata <= {28'h0, chan_ctl};
          DGT_SEL_THRESH: s_axi_rdata <= {24'h0, line_level_threshold};
          DGT_SEL_IRQCTL: s_axi_rdata <= {28'h0, irq_ctl};
          DGT_SEL_STATUS: s_axi_rdata <= {31'h0, event_status};
          DGT_SEL_MASK: s_axi_rdata <= {31'h0, event_mask};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************
  // plain read/write fields, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fine_gain <= dgt_fine_gain_t'(RST_REG8[4:0]);
      chan_ctl <= dgt_chan_ctl_t'(RST_REG8[3:0]);
      line_level_threshold <= RST_REG8;
      ctl_low[POS_SEL] <= RST_REG8[POS_SEL];
      ctl_low[POS_MASK] <= RST_REG8[POS_MASK];
      ctl_low[POS_POL] <= RST_REG8[POS_POL];
      event_mask <= RST_REG8[0:0];
    end else if (wr_lane0) begin
      case (wr_sel)
        DGT_SEL_GAIN: fine_gain <= dgt_fine_gain_t'(w_data[4:0]);
        DGT_SEL_FORMAT: chan_ctl <= dgt_chan_ctl_t'(w_data[3:0]);
        DGT_SEL_THRESH: line_level_threshold <= w_data[7:0]; // [RULE10]
        DGT_SEL_IRQCTL: begin
          ctl_low[POS_SEL] <= w_data[POS_SEL]; // [RULE11]
          ctl_low[POS_MASK] <= w_data[POS_MASK];
          ctl_low[POS_POL] <= w_data[POS_POL]; // [RULE12]
        end
        DGT_SEL_MASK: event_mask <= w_data[POS_EVT_THRESH +: 1];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // threshold comparator
  // ****************************************************
  // current or voltage chosen by select bit
  assign level_raw = irq_ctl.sel ? line_voltage_value
                                 : line_current_value; // [RULE11]
  assign level_abs = dgt_abs(level_raw);
  // evaluated only when a new measurement arrives [RULE17]
  assign cross_now = measure_update &&
    (irq_ctl.pol ? (level_abs > {1'b0, line_level_threshold})
                 : (level_abs < {1'b0, line_level_threshold})); // [RULE12]

  // sticky flag: set wins, zero write clears, one write keeps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_flag <= RST_REG8[POS_FLAG];
    end else if (cross_now) begin
      level_flag <= 1'b1; // [RULE13] [RULE15]
    end else if (wr_lane0 && wr_sel == DGT_SEL_IRQCTL &&
                 !w_data[POS_FLAG]) begin
      level_flag <= 1'b0; // [RULE13] [RULE16]
    end
  end

  // event status: set wins over clear on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= RST_REG8[0:0];
    end else if (cross_now) begin
      event_status <= 1'b1;
    end else if (rd_take && rd_sel == DGT_SEL_STATUS) begin
      event_status <= 1'b0;
    end
  end

  // global enable arrives from outside, two stage sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_meta <= 1'b0;
      gie_sync <= 1'b0;
    end else begin
      gie_meta <= global_irq_enable;
      gie_sync <= gie_meta;
    end
  end

  // interrupt pin, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_output_pin <= 1'b0;
    end else begin
      irq_output_pin <= gie_sync && irq_ctl.mask && // [RULE14]
        (irq_ctl.flag || |(event_status & event_mask)); // [RULE15]
    end
  end

  // ****************************************************
  // receive fine gain
  // ****************************************************
  // signed gain in tenths of a dB, attenuation negative
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_fine_dir <= 1'b0;
      rx_fine_steps <= RST_REG8[3:0];
      rx_fine_gain_tenths <= '0;
    end else begin
      rx_fine_dir <= fine_gain.dir;
      rx_fine_steps <= fine_gain.steps; // [RULE3]
      rx_fine_gain_tenths <= fine_gain.dir // [RULE2]
        ? -$signed({2'b00, fine_gain.steps})
        : $signed({2'b00, fine_gain.steps}); // zero steps gives 0 [RULE3]
    end
  end

  // ****************************************************
  // channel transmit path
  // ****************************************************
  // route one sample into the assigned channel if enabled, into both enabled channels in 16-bit mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_data_format <= RST_REG8[1:0];
      b1_tx_byte <= RST_REG8;
      b2_tx_byte <= RST_REG8;
      b1_tx_valid <= 1'b0;
      b2_tx_valid <= 1'b0;
    end else begin
      channel_data_format <= chan_ctl.fmt; // [RULE4]
      b1_tx_valid <= 1'b0;
      b2_tx_valid <= 1'b0;
      if (tx_valid) begin
        case (chan_ctl.fmt)
          DGT_FMT_LIN16: begin
            // both channels regardless of assignment [RULE5]
            b1_tx_byte <= tx_sample[15:8]; // [RULE7]
            b2_tx_byte <= tx_sample[7:0]; // [RULE9]
            b1_tx_valid <= chan_ctl.b1_en; // [RULE8]
            b2_tx_valid <= chan_ctl.b2_en; // [RULE6]
          end
          DGT_FMT_LIN8: begin
            // low byte dropped [RULE4]
            b1_tx_byte <= tx_sample[15:8];
            b2_tx_byte <= tx_sample[15:8];
            b1_tx_valid <= !channel_assign && chan_ctl.b1_en; // [RULE8]
            b2_tx_valid <= channel_assign && chan_ctl.b2_en; // [RULE6]
          end
          default: begin
            // companded byte from the codec [RULE4]
            b1_tx_byte <= tx_coded;
            b2_tx_byte <= tx_coded;
            b1_tx_valid <= !channel_assign && chan_ctl.b1_en; // [RULE8]
            b2_tx_valid <= channel_assign && chan_ctl.b2_en; // [RULE6]
          end
        endcase
      end
    end
  end

  // ****************************************************
  // channel receive path
  // ****************************************************
  // disabled channels contribute zero in 16-bit mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sample <= RST_SAMPLE;
      rx_coded <= RST_REG8;
      rx_sample_valid <= 1'b0;
    end else begin
      rx_sample_valid <= 1'b0;
      if (rx_valid) begin
        case (chan_ctl.fmt)
          DGT_FMT_LIN16: begin
            rx_sample <= {chan_ctl.b1_en ? b1_rx_byte : 8'h00, // [RULE7]
                          chan_ctl.b2_en ? b2_rx_byte : 8'h00}; // [RULE9]
            rx_sample_valid <= chan_ctl.b1_en || chan_ctl.b2_en; // [RULE5]
          end
          DGT_FMT_LIN8: begin
            rx_sample <= {channel_assign ? b2_rx_byte : b1_rx_byte, 8'h00};
            rx_sample_valid <= channel_assign ? chan_ctl.b2_en // [RULE6]
                                              : chan_ctl.b1_en; // [RULE8]
          end
          default: begin
            rx_coded <= channel_assign ? b2_rx_byte : b1_rx_byte;
            rx_sample_valid <= channel_assign ? chan_ctl.b2_en
                                              : chan_ctl.b1_en;
          end
        endcase
      end
    end
  end

endmodule // dgt_regs

// ===== sim/dgt_regs_chk.sv
`timescale 1ns/1ps
module dgt_regs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dgt_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic rx_fine_dir,
  input wire logic [3:0] rx_fine_steps,
  input wire logic signed [5:0] rx_fine_gain_tenths,
  input wire logic [1:0] channel_data_format,
  input wire logic [15:0] tx_sample,
  input wire logic tx_valid,
  input wire logic [7:0] b1_tx_byte,
  input wire logic b1_tx_valid,
  input wire logic [7:0] b2_tx_byte,
  input wire logic b2_tx_valid,
  input wire logic rx_valid,
  input wire logic rx_sample_valid
);
  import dgt_pkg::*;
  // ****
  // bus and data path relations
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_R_ONE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_LOW: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high during answer");
  AST_R_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_GAIN: assert property (
    $stable(rx_fine_dir) && $stable(rx_fine_steps) |->
    rx_fine_gain_tenths == (rx_fine_dir ? 6'h00 - {2'h0, rx_fine_steps} :
    {2'h0, rx_fine_steps}))
    else $error("gain tenths wrong");
  AST_TX_HI: assert property (
    b1_tx_valid && $past(channel_data_format) == 2'h3 |->
    b1_tx_byte == $past(tx_sample[15:8]))
    else $error("first channel byte wrong");
  AST_TX_LO: assert property (
    b2_tx_valid && $past(channel_data_format) == 2'h3 |->
    b2_tx_byte == $past(tx_sample[7:0]))
    else $error("second channel byte wrong");
  AST_TX_CAUSE: assert property (
    b1_tx_valid || b2_tx_valid |-> $past(tx_valid))
    else $error("transfer without sample");
  AST_RX_CAUSE: assert property (rx_sample_valid |-> $past(rx_valid))
    else $error("receive without bytes");
endmodule // dgt_regs_chk

// ===== sim/dgt_line_model.sv
`timescale 1ns/1ps
module dgt_line_model (
  input wire logic aclk,
  output logic [7:0] line_current_value,
  output logic [7:0] line_voltage_value,
  output logic measure_update,
  output logic [7:0] b1_rx_byte,
  output logic [7:0] b2_rx_byte,
  output logic rx_valid,
  input wire logic [7:0] b1_tx_byte,
  input wire logic b1_tx_valid,
  input wire logic [7:0] b2_tx_byte,
  input wire logic b2_tx_valid
);
  int n1 = 0;
  int n2 = 0;
  logic [7:0] last1 = 8'h00;
  logic [7:0] last2 = 8'h00;
  // idle values at time zero
  initial begin
    line_current_value = 8'h00;
    line_voltage_value = 8'h00;
    measure_update = 1'b0;
    b1_rx_byte = 8'h00;
    b2_rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  // capture what the device sends on each channel
  always @(posedge aclk) begin
    if (b1_tx_valid) begin
      n1 <= n1 + 1;
      last1 <= b1_tx_byte;
    end
    if (b2_tx_valid) begin
      n2 <= n2 + 1;
      last2 <= b2_tx_byte;
    end
  end
  // new measurement, one update pulse
  task automatic measure(input logic [7:0] c, input logic [7:0] v);
    line_current_value <= c;
    line_voltage_value <= v;
    measure_update <= 1'b1;
    @(posedge aclk);
    measure_update <= 1'b0;
  endtask
  // receive bytes, lines inverted once released
  task automatic send_rx(input logic [7:0] a, input logic [7:0] b);
    b1_rx_byte <= a;
    b2_rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_valid <= 1'b0;
    b1_rx_byte <= ~a;
    b2_rx_byte <= ~b;
  endtask
endmodule // dgt_line_model

// ===== sim/dgt_regs_bench.sv
`timescale 1ns/1ps
module dgt_regs_bench;
  import dgt_pkg::*;
  localparam logic [7:0] A_GAIN = {IDX_RX_FINE_GAIN, 2'h0};
  localparam logic [7:0] A_FMT = {IDX_CHANNEL_FORMAT, 2'h0};
  localparam logic [7:0] A_THR = {IDX_LEVEL_THRESHOLD, 2'h0};
  localparam logic [7:0] A_CTL = {IDX_LEVEL_IRQ_CTRL, 2'h0};
  localparam logic [7:0] A_STS = {IDX_EVENT_STATUS, 2'h0};
  localparam logic [7:0] A_MSK = {IDX_EVENT_MASK, 2'h0};
  localparam logic [7:0] CFG [7] = '{8'h0f, 8'h0d, 8'h0e, 8'h0b, 8'h03,
    8'h07, 8'h05};
  localparam logic [6:0] ASG = 7'h50;
  localparam logic [6:0] E1 = 7'h2b;
  localparam logic [6:0] E2 = 7'h15;
  int n_errors = 0;
  int num_checks = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, measure_update, rx_valid, irq_output_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, channel_data_format;
  logic [7:0] line_current_value, line_voltage_value, b1_rx_byte;
  logic [7:0] b2_rx_byte, b1_tx_byte, b2_tx_byte, rx_coded;
  logic [7:0] tx_coded = 8'h3c;
  logic global_irq_enable = 1'b0, channel_assign = 1'b0, tx_valid = 1'b0;
  logic rx_fine_dir, b1_tx_valid, b2_tx_valid, rx_sample_valid;
  logic [3:0] rx_fine_steps;
  logic signed [5:0] rx_fine_gain_tenths;
  logic [15:0] tx_sample = 16'ha55a;
  logic [15:0] rx_sample;
  // ****
  // clock, design and line side
  // ****
  initial begin
    forever #5 aclk = ~aclk;
  end
  dgt_regs i_dgt_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_current_value,
    .line_voltage_value, .measure_update, .global_irq_enable,
    .irq_output_pin, .rx_fine_dir, .rx_fine_steps, .rx_fine_gain_tenths,
    .channel_data_format, .channel_assign, .tx_sample, .tx_coded,
    .tx_valid, .b1_tx_byte, .b1_tx_valid, .b2_tx_byte, .b2_tx_valid,
    .b1_rx_byte, .b2_rx_byte, .rx_valid, .rx_sample, .rx_coded,
    .rx_sample_valid);
  dgt_line_model i_dgt_line_model (.aclk, .line_current_value,
    .line_voltage_value, .measure_update, .b1_rx_byte, .b2_rx_byte,
    .rx_valid, .b1_tx_byte, .b1_tx_valid, .b2_tx_byte, .b2_tx_valid);
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // write, handshakes judged from values settled before the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    logic awt, wt, bt;
    n = 0;
    bt = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!bt && n < 50) begin
      @(negedge aclk);
      awt = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      if (bt) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (awt) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      n++;
    end
    if (!bt) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // read and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] er);
    int n;
    logic art, rt;
    n = 0;
    rt = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rt && n < 50) begin
      @(negedge aclk);
      art = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid;
      if (rt) chk(s_axi_rdata, {24'h00_0000, e});
      if (rt) chk(s_axi_rresp, er);
      @(posedge aclk);
      if (art) s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!rt) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rdc(A_GAIN, 8'h00, RESP_OKAY);
    rdc(A_FMT, 8'h00, RESP_OKAY);
    rdc(A_THR, 8'h00, RESP_OKAY);
    rdc(A_CTL, 8'h00, RESP_OKAY);
    rdc(A_STS, 8'h00, RESP_OKAY);
    rdc(A_MSK, 8'h00, RESP_OKAY);
    rdc(8'h00, 8'h00, RESP_SLVERR);
    wr(8'ha5, 8'hff, RESP_SLVERR);
    rdc(A_GAIN, 8'h00, RESP_OKAY);
  endtask
  task automatic t_regs;
    logic [7:0] v [4];
    logic [5:0] g;
    v = '{8'hff, 8'h10, 8'h0f, 8'h01};
    for (int i = 0; i < 4; i++) begin
      wr(A_GAIN, v[i], RESP_OKAY);
      rdc(A_GAIN, v[i] & 8'h1f, RESP_OKAY);
      tick(2);
      g = v[i][4] ? 6'h00 - v[i][3:0] : {2'h0, v[i][3:0]};
      chk({26'h0, rx_fine_gain_tenths}, {26'h0, g});
    end
    wr(A_FMT, 8'hff, RESP_OKAY);
    rdc(A_FMT, 8'h0f, RESP_OKAY);
    wr(A_THR, 8'hff, RESP_OKAY);
    rdc(A_THR, 8'hff, RESP_OKAY);
    wr(A_CTL, 8'hff, RESP_OKAY);
    rdc(A_CTL, 8'h07, RESP_OKAY);
    wr(A_CTL, 8'h00, RESP_OKAY);
  endtask
  task automatic t_tx;
    int c1, c2;
    logic [1:0] f;
    for (int i = 0; i < 7; i++) begin
      f = CFG[i][3:2];
      wr(A_FMT, CFG[i], RESP_OKAY);
      channel_assign <= ASG[i];
      c1 = i_dgt_line_model.n1;
      c2 = i_dgt_line_model.n2;
      tx_valid <= 1'b1;
      @(posedge aclk);
      tx_valid <= 1'b0;
      tick(2);
      chk(channel_data_format, f);
      chk(i_dgt_line_model.n1 - c1, E1[i]);
      chk(i_dgt_line_model.n2 - c2, E2[i]);
      if (E1[i]) chk(i_dgt_line_model.last1,
        f[1] ? 8'ha5 : 8'h3c);
      if (E2[i]) chk(i_dgt_line_model.last2,
        f == 2'h3 ? 8'h5a : f[1] ? 8'ha5 : 8'h3c);
    end
  endtask
  task automatic t_rx;
    wr(A_FMT, 8'h0f, RESP_OKAY);
    channel_assign <= 1'b0;
    i_dgt_line_model.send_rx(8'h12, 8'h34);
    #1;
    chk(rx_sample_valid, 1'b1);
    chk(rx_sample, 16'h1234);
    wr(A_FMT, 8'h03, RESP_OKAY);
    i_dgt_line_model.send_rx(8'h5a, 8'h77);
    #1;
    chk(rx_coded, 8'h5a);
  endtask
  task automatic t_thresh;
    wr(A_THR, 8'h20, RESP_OKAY);
    wr(A_CTL, 8'h03, RESP_OKAY);
    global_irq_enable <= 1'b1;
    tick(4);
    i_dgt_line_model.measure(8'h20, 8'h00);
    tick(1);
    rdc(A_CTL, 8'h03, RESP_OKAY);
    i_dgt_line_model.measure(8'hd0, 8'h00);
    tick(1);
    chk(irq_output_pin, 1'b1);
    rdc(A_CTL, 8'h0b, RESP_OKAY);
    wr(A_CTL, 8'h0b, RESP_OKAY);
    rdc(A_CTL, 8'h0b, RESP_OKAY);
    wr(A_CTL, 8'h03, RESP_OKAY);
    tick(1);
    chk(irq_output_pin, 1'b0);
    rdc(A_CTL, 8'h03, RESP_OKAY);
    wr(A_CTL, 8'h04, RESP_OKAY);
    i_dgt_line_model.measure(8'h10, 8'h7f);
    tick(1);
    rdc(A_CTL, 8'h04, RESP_OKAY);
    i_dgt_line_model.measure(8'h7f, 8'h10);
    tick(1);
    chk(irq_output_pin, 1'b0);
    rdc(A_CTL, 8'h0c, RESP_OKAY);
    wr(A_CTL, 8'h06, RESP_OKAY);
    global_irq_enable <= 1'b0;
    tick(4);
    i_dgt_line_model.measure(8'h00, 8'h10);
    tick(1);
    chk(irq_output_pin, 1'b0);
    global_irq_enable <= 1'b1;
    tick(4);
    chk(irq_output_pin, 1'b1);
    wr(A_CTL, 8'h04, RESP_OKAY);
    tick(1);
    chk(irq_output_pin, 1'b0);
    rdc(A_STS, 8'h01, RESP_OKAY);
    rdc(A_STS, 8'h00, RESP_OKAY);
    wr(A_MSK, 8'h01, RESP_OKAY);
    i_dgt_line_model.measure(8'h00, 8'h10);
    tick(1);
    chk(irq_output_pin, 1'b0);
    wr(A_CTL, 8'h06, RESP_OKAY);
    tick(1);
    chk(irq_output_pin, 1'b1);
    rdc(A_STS, 8'h01, RESP_OKAY);
    tick(1);
    chk(irq_output_pin, 1'b0);
  endtask
  // ****
  // run and verdict
  // ****
  task automatic summarize;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence after a 12 cycle reset
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_thresh;
    summarize;
  end
  // watchdog against a hung handshake
  initial begin
    #100us;
    n_errors++;
    summarize;
  end
endmodule // dgt_regs_bench
bind dgt_regs dgt_regs_chk i_dgt_regs_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .rx_fine_dir, .rx_fine_steps,
  .rx_fine_gain_tenths, .channel_data_format, .tx_sample, .tx_valid,
  .b1_tx_byte, .b1_tx_valid, .b2_tx_byte, .b2_tx_valid, .rx_valid,
  .rx_sample_valid);
